// ===== logic/prc_top.sv
// Our own choice: register access over APB.
`timescale 1ns/10ps
`include "prc_params.svh"
module prc_top
	import prc_pkg::*;
(
	input wire logic CORE_CLK, // 125 MHz core clock
	input wire logic RST, // sync reset, active high
	input wire logic PSEL, // apb select
	input wire logic PENABLE, // apb enable
	input wire logic PWRITE, // apb direction
	input wire logic [11:0] PADDR, // apb byte address
	input wire logic [31:0] PWDATA, // apb write data
	output prc_pkg::prc_word_t PRDATA, // apb read data
	output logic PREADY, // apb ready
	output logic PSLVERR, // apb error
	input wire logic [31:0] CAP_TWO, // capability_reg_two
	input wire logic [31:0] CAP_FOUR, // capability_reg_four
	output prc_pkg::prc_resets_s RESETS // peripheral reset requests
);
	import prc_pkg::*;
	logic wr_one;
	logic wr_two;
	logic rd_one;
	logic rd_two;
	logic access;
	logic bad;
	logic [31:0] ctrl_one_q;
	logic [31:0] ctrl_two_q;
	logic [31:0] rdata_d;
	prc_resets_s resets_d;
	logic rdy_q;

	prc_apb_slave u_bus (
		.clk(CORE_CLK),
		.rst(RST),
		.psel(PSEL),
		.penable(PENABLE),
		.pwrite(PWRITE),
		.paddr(PADDR),
		.wr_one(wr_one),
		.wr_two(wr_two),
		.rd_one(rd_one),
		.rd_two(rd_two),
		.access(access),
		.bad(bad)
	);

	// register one, masked by capability two
	prc_mask_reg #(.IMPL(`PRC_IMPL_ONE)) u_one (
		.clk(CORE_CLK),
		.rst(RST),
		.wr(wr_one),
		.wdata(PWDATA),
		.cap(CAP_TWO),
		.value_q(ctrl_one_q)
	);

	// register two, masked by capability four
	prc_mask_reg #(.IMPL(`PRC_IMPL_TWO)) u_two (
		.clk(CORE_CLK),
		.rst(RST),
		.wr(wr_two),
		.wdata(PWDATA),
		.cap(CAP_FOUR),
		.value_q(ctrl_two_q)
	);

	// read mux; reserved bits are already zero in storage
	always_comb begin
		rdata_d = 32'h0000_0000;
		if (rd_one) begin
			rdata_d = ctrl_one_q;
		end else if (rd_two) begin
			rdata_d = ctrl_two_q;
		end
	end

	// map stored bits onto the reset request lines
	always_comb begin
		resets_d.comparator_zero_reset = ctrl_one_q[`PRC_BIT_COMPARATOR_ZERO_RESET];
		resets_d.gp_counter_zero_reset = ctrl_one_q[`PRC_BIT_TMR0];
		resets_d.gp_counter_one_reset = ctrl_one_q[`PRC_BIT_TMR1];
		resets_d.gp_counter_two_reset = ctrl_one_q[`PRC_BIT_TMR2];
		resets_d.two_wire_unit_reset = ctrl_one_q[`PRC_BIT_TWI];
		resets_d.sync_serial_unit_reset = ctrl_one_q[`PRC_BIT_SSU];
		resets_d.async_serial_port_reset = ctrl_one_q[`PRC_BIT_ASP];
		resets_d.universal_bus_unit_reset = ctrl_two_q[`PRC_BIT_USB];
		resets_d.dma_unit_reset = ctrl_two_q[`PRC_BIT_DMA];
		resets_d.port_a_reset = ctrl_two_q[`PRC_BIT_PORTA];
		resets_d.port_b_reset = ctrl_two_q[`PRC_BIT_PORTA + 1];
		resets_d.port_c_reset = ctrl_two_q[`PRC_BIT_PORTA + 2];
		resets_d.port_d_reset = ctrl_two_q[`PRC_BIT_PORTA + 3];
		resets_d.port_e_reset = ctrl_two_q[`PRC_BIT_PORTA + 4];
	end

	// reset lines are level holds, registered so outputs are glitch free;
	// this costs one cycle of lag after the write
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			RESETS <= '0;
		end else begin
			RESETS <= resets_d;
		end
	end

	// rdy_q toggles on access but drives nothing; PREADY is set from the setup phase, so no wait states
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			rdy_q <= 1'b0;
		end else begin
			rdy_q <= access & ~rdy_q;
		end
	end

	// registered answer; slverr only on an unmapped address
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			PREADY <= 1'b0;
			PSLVERR <= 1'b0;
			PRDATA <= `PRC_RST_VAL;
		end else begin
			PREADY <= 1'b0;
			PSLVERR <= 1'b0;
			if (PSEL & ~PENABLE) begin
				PREADY <= 1'b1;
				PSLVERR <= bad;
				PRDATA <= PWRITE ? 32'h0000_0000 : rdata_d;
			end
		end
	end
endmodule

// ===== logic/prc_params.svh
`ifndef PRC_PARAMS_SVH
`define PRC_PARAMS_SVH
// register byte offsets
`define PRC_OFS_CTRL_ONE 12'h044
`define PRC_OFS_CTRL_TWO 12'h048
`define PRC_ADDR_W 12
// reset values
`define PRC_RST_VAL 32'h0000_0000
// implemented bits, register one
`define PRC_BIT_COMPARATOR_ZERO_RESET 24
`define PRC_BIT_TMR0 16
`define PRC_BIT_TMR1 17
`define PRC_BIT_TMR2 18
`define PRC_BIT_TWI 12
`define PRC_BIT_SSU 4
`define PRC_BIT_ASP 0
// implemented bits, register two
`define PRC_BIT_USB 16
`define PRC_BIT_DMA 13
`define PRC_BIT_PORTA 0
`define PRC_NUM_PORTS 5
// masks of implemented bits
`define PRC_IMPL_ONE 32'h0107_1011
`define PRC_IMPL_TWO 32'h0001_201F
`endif

// ===== logic/prc_pkg.sv
package prc_pkg;
	typedef struct packed {
		logic comparator_zero_reset;
		logic gp_counter_two_reset;
		logic gp_counter_one_reset;
		logic gp_counter_zero_reset;
		logic two_wire_unit_reset;
		logic sync_serial_unit_reset;
		logic async_serial_port_reset;
		logic universal_bus_unit_reset;
		logic dma_unit_reset;
		logic port_e_reset;
		logic port_d_reset;
		logic port_c_reset;
		logic port_b_reset;
		logic port_a_reset;
	} prc_resets_s;
	typedef logic [31:0] prc_word_t;
endpackage

// ===== logic/prc_mask_reg.sv
`timescale 1ns/10ps
`include "prc_params.svh"
// one reset-control word: capability-masked write, reserved bits stay zero
module prc_mask_reg #(
	parameter logic [31:0] IMPL = 32'h0000_0000
) (
	input wire logic clk, // core clock
	input wire logic rst, // sync reset
	input wire logic wr, // write strobe
	input wire logic [31:0] wdata, // write data
	input wire logic [31:0] cap, // capability mask
	output logic [31:0] value_q // stored value
);
	logic [31:0] keep;
	logic [31:0] value_d;
	// only present, implemented bits may change on a write
	assign keep = IMPL & cap;
	assign value_d = (value_q & ~keep) | (wdata & keep);
	// reserved bits never load, so they read as zero
	always_ff @(posedge clk) begin
		if (rst) begin
			value_q <= `PRC_RST_VAL;
		end else if (wr) begin
			value_q <= value_d & IMPL;
		end
	end
endmodule

// ===== logic/prc_apb_slave.sv
`timescale 1ns/10ps
`include "prc_params.svh"
// apb slave front end: zero wait states, slverr on unmapped address
module prc_apb_slave (
	input wire logic clk, // core clock
	input wire logic rst, // sync reset
	input wire logic psel, // select
	input wire logic penable, // access phase
	input wire logic pwrite, // direction
	input wire logic [11:0] paddr, // byte address
	output logic wr_one, // write to register one
	output logic wr_two, // write to register two
	output logic rd_one, // read hit register one
	output logic rd_two, // read hit register two
	output logic access, // access phase this cycle
	output logic bad // unmapped address
);
	logic hit_one;
	logic hit_two;
	// word-aligned decode, low two address bits ignored
	assign hit_one = paddr[11:2] == `PRC_OFS_CTRL_ONE >> 2;
	assign hit_two = paddr[11:2] == `PRC_OFS_CTRL_TWO >> 2;
	assign access = psel & penable;
	assign wr_one = access & pwrite & hit_one;
	assign wr_two = access & pwrite & hit_two;
	assign rd_one = hit_one;
	assign rd_two = hit_two;
	assign bad = ~(hit_one | hit_two);
endmodule

// ===== dv/prc_props.sv
`timescale 1ns/10ps
`include "prc_params.svh"
// watches the apb port and the reset request outputs
module prc_props
	import prc_pkg::*;
(
	input wire logic CORE_CLK, // clock
	input wire logic RST, // sync reset
	input wire logic PSEL, // select
	input wire logic PENABLE, // enable
	input wire logic PWRITE, // direction
	input wire logic [11:0] PADDR, // address
	input wire logic [31:0] PWDATA, // write data
	input wire prc_pkg::prc_word_t PRDATA, // read data
	input wire logic PREADY, // ready
	input wire logic PSLVERR, // error
	input wire logic [31:0] CAP_TWO, // mask one
	input wire logic [31:0] CAP_FOUR, // mask two
	input wire prc_pkg::prc_resets_s RESETS // requests
);
	// completed writes and the implemented bits they touch
	wire logic acc = PSEL && PENABLE && PWRITE && PREADY;
	wire logic w1 = acc && PADDR == `PRC_OFS_CTRL_ONE;
	wire logic w2 = acc && PADDR == `PRC_OFS_CTRL_TWO;
	wire logic wr = w1 || w2;
	wire logic [6:0] e1 = {PWDATA[24], PWDATA[18:16], PWDATA[12],
		PWDATA[4], PWDATA[0]};
	wire logic [6:0] m1 = {CAP_TWO[24], CAP_TWO[18:16], CAP_TWO[12],
		CAP_TWO[4], CAP_TWO[0]};
	wire logic [6:0] e2 = {PWDATA[16], PWDATA[13], PWDATA[4:0]};
	wire logic [6:0] m2 = {CAP_FOUR[16], CAP_FOUR[13], CAP_FOUR[4:0]};
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (RST);
	sequence s_setup;
		PSEL && !PENABLE;
	endsequence
	sequence s_bad;
		s_setup ##0 (PADDR != `PRC_OFS_CTRL_ONE && PADDR != `PRC_OFS_CTRL_TWO);
	endsequence
	AST_READY: assert property (s_setup |=> PREADY)
		else $error("no ready after setup");
	AST_ERR: assert property (s_bad |=> PSLVERR)
		else $error("unmapped address accepted");
	// outputs lag the register by one edge, hence two cycles
	AST_ONE: assert property (w1 |-> ##2 RESETS[13:7] ==
		($past(e1, 2) & $past(m1, 2) | $past(RESETS[13:7]) & ~$past(m1, 2)))
		else $error("register one write wrong");
	AST_TWO: assert property (w2 |-> ##2 RESETS[6:0] ==
		($past(e2, 2) & $past(m2, 2) | $past(RESETS[6:0]) & ~$past(m2, 2)))
		else $error("register two write wrong");
	AST_HOLD: assert property (!$past(wr, 2) && !$past(RST) |-> $stable(RESETS))
		else $error("reset request moved without write");
	AST_CLR: assert property (disable iff (1'b0) RST |=> RESETS == '0)
		else $error("requests not cleared");
	AST_RSV1: assert property (PREADY && !PWRITE && PADDR == `PRC_OFS_CTRL_ONE
		|-> !(PRDATA & ~`PRC_IMPL_ONE)) else $error("reserved one set");
	AST_RSV2: assert property (PREADY && !PWRITE && PADDR == `PRC_OFS_CTRL_TWO
		|-> !(PRDATA & ~`PRC_IMPL_TWO)) else $error("reserved two set");
endmodule
bind prc_top prc_props u_props (.CORE_CLK, .RST, .PSEL, .PENABLE, .PWRITE,
	.PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR, .CAP_TWO, .CAP_FOUR, .RESETS);

// ===== dv/testbench.sv
`timescale 1ns/10ps
`include "prc_params.svh"
module testbench;
	import prc_pkg::*;
	logic CORE_CLK = 0, RST = 1, PSEL = 0, PENABLE = 0, PWRITE = 0;
	logic [11:0] PADDR = 0;
	logic [31:0] PWDATA = 0, CAP_TWO = 0, CAP_FOUR = 0;
	logic [31:0] r1 = 0, r2 = 0, c, d, s = 32'h0001_15E7;
	prc_word_t PRDATA;
	logic PREADY, PSLVERR;
	prc_resets_s RESETS;
	logic [33:0] q[$], t; // notes: {read, error, data}
	int error_cnt = 0, cmp_count = 0;
	prc_top uut (.CORE_CLK, .RST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA,
		.PRDATA, .PREADY, .PSLVERR, .CAP_TWO, .CAP_FOUR, .RESETS);
	initial forever #4 CORE_CLK = ~CORE_CLK;
	function logic [31:0] nx(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	task cmp(input logic [32:0] got, input logic [32:0] exp);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task print_verdict;
		$display("compares %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// psel stays up so transfers can run back to back
	task apb(input logic [11:0] a, input logic w, input logic [31:0] dw,
		input logic [31:0] e);
		int n;
		q.push_back({!w, a != `PRC_OFS_CTRL_ONE && a != `PRC_OFS_CTRL_TWO, e});
		PSEL <= 1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= dw;
		@(posedge CORE_CLK);
		PENABLE <= 1;
		n = 0;
		do begin
			@(posedge CORE_CLK);
			n++;
		end while (PREADY !== 1 && n < 9);
		if (PREADY !== 1) begin
			error_cnt++;
			print_verdict;
		end
		PENABLE <= 0;
	endtask
	// reads are compared whole, writes only on the error flag
	always @(posedge CORE_CLK) begin
		if (PSEL && PENABLE && PREADY === 1 && q.size() > 0) begin
			t = q.pop_front();
			cmp({PSLVERR, t[33] ? PRDATA : 32'h0}, t[32:0]);
		end
	end
	initial begin
		repeat (10) @(posedge CORE_CLK);
		RST <= 0;
		@(posedge CORE_CLK);
		apb(`PRC_OFS_CTRL_ONE, 0, 0, 0);
		apb(`PRC_OFS_CTRL_TWO, 0, 0, 0);
		apb(12'h04C, 1, 32'hFFFF_FFFF, 0);
		apb(12'h040, 0, 0, 0);
		$display("reset and unmapped test done");
		for (int i = 0; i < 16; i++) begin
			d = i == 15 ? 32'h0 : nx(s);
			s = nx(d);
			c = i < 2 || i == 15 ? 32'hFFFF_FFFF : s;
			CAP_TWO <= c;
			CAP_FOUR <= c;
			r1 = (r1 & ~c | d & c) & `PRC_IMPL_ONE;
			r2 = (r2 & ~c | ~d & c) & `PRC_IMPL_TWO;
			apb(`PRC_OFS_CTRL_ONE, 1, d, 0);
			apb(`PRC_OFS_CTRL_TWO, 1, ~d, 0);
			apb(`PRC_OFS_CTRL_ONE, 0, 0, r1);
			apb(`PRC_OFS_CTRL_TWO, 0, 0, r2);
			cmp({19'h0, RESETS}, {19'h0, r1[24], r1[18:16], r1[12], r1[4], r1[0], r2[16], r2[13], r2[4:0]});
		end
		PSEL <= 0;
		@(posedge CORE_CLK);
		$display("masked write test done");
		print_verdict;
	end
endmodule
